// ==== rtl/arci_top.sv ====
/*
  digital control behind the isolated analog remote interface of a dc load:
  pin decode, alarm grouping, acknowledgment, status pin, set value gating,
  avalon-mm register slave.
  assumes converters sample/drive 14-bit codes on core_clk_i and that the
  controller pins arrive asynchronously.
*/
`timescale 1ns/100ps
`include "arci_defs.svh"

module arci_top #(
  parameter int unsigned ACK_CYC = `ARCI_ACK_CYC
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // avalon-mm slave
  input  wire logic [4:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // controller pins (asynchronous)
  input  wire logic                 remote_sel_pin_i,
  input  wire logic                 rmode_pin_i,
  input  wire logic                 standby_pin_i,
  // device alarm sources and regulator state
  input  wire arci_pkg::arci_alarm_t alarm_src_i,
  input  wire logic                 cv_active_i,
  input  wire logic                 dc_on_i,
  // converter codes
  input  wire arci_pkg::arci_code_t voltage_setpoint_in_i,
  input  wire arci_pkg::arci_code_t current_setpoint_in_i,
  input  wire arci_pkg::arci_code_t resistance_setpoint_in_i,
  input  wire arci_pkg::arci_code_t volt_actual_i,
  input  wire arci_pkg::arci_code_t curr_actual_i,
  // outputs to the power stage and panel
  output arci_pkg::arci_code_t      volt_set_o,
  output arci_pkg::arci_code_t      curr_set_o,
  output arci_pkg::arci_code_t      res_set_o,
  output logic                      set_valid_o,
  output logic                      rmode_on_o,
  output logic                      dc_on_req_o,
  output logic                      alarm_trip_o,
  output logic                      alarm_ack_o,
  output logic                      vref_10v_o,
  // monitor codes and interface pins
  output arci_pkg::arci_code_t      voltage_monitor_out_o,
  output arci_pkg::arci_code_t      current_monitor_out_o,
  output logic                      alarm1_pin_o,
  output logic                      alarm2_pin_o,
  output logic                      status_pin_o
);
  import arci_pkg::*;

  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        remote_act;
  logic        rmode_lvl;
  logic        sby_lvl;
  logic [`ARCI_CTRL_W-1:0] ctrl_r;
  arci_alarm_t almask_r;
  arci_alarm_t al_sel;
  arci_ack_t   ack_st_r;
  logic [31:0] low_cnt_r;
  logic [7:0]  ack_cnt_r;
  logic        ack_pulse;
  logic        range10;
  logic        acc;
  logic        bank_lo;
  logic [3:0]  ofs;
  logic [31:0] rd_nxt;
  logic        rd_done_r;

  // two-stage synchronisers
  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else begin
      sync1_r <= {standby_pin_i, rmode_pin_i, remote_sel_pin_i};
      sync2_r <= sync1_r;
    end
  end

  assign remote_act = ~sync2_r[0];
  assign rmode_lvl  = sync2_r[1];
  assign sby_lvl    = sync2_r[2];
  assign range10    = ctrl_r[`ARCI_CTRL_RANGE10];

  // standby pin works in every mode
  assign dc_on_req_o = sby_lvl;
  assign rmode_on_o  = rmode_lvl;
  assign vref_10v_o  = range10;

  // set values gated by remote select
  // 5 V range drops the lsb (half resolution)
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      volt_set_o  <= '0;
      curr_set_o  <= '0;
      res_set_o   <= '0;
      set_valid_o <= 1'b0;
    end else begin
      set_valid_o <= remote_act;
      if (remote_act) begin
        volt_set_o <= range10 ? voltage_setpoint_in_i : (voltage_setpoint_in_i & ~14'h0001);
        curr_set_o <= range10 ? current_setpoint_in_i : (current_setpoint_in_i & ~14'h0001);
        res_set_o  <= range10 ? resistance_setpoint_in_i
                              : (resistance_setpoint_in_i & ~14'h0001);
      end
    end
  end

  // full range maps to the selected voltage span downstream
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      voltage_monitor_out_o <= '0;
      current_monitor_out_o <= '0;
    end else begin
      voltage_monitor_out_o <= range10 ? volt_actual_i : (volt_actual_i & ~14'h0001);
      current_monitor_out_o <= range10 ? curr_actual_i : (curr_actual_i & ~14'h0001);
    end
  end

  assign al_sel = alarm_src_i & almask_r;

  // alarm trips dc input off as in manual mode
  // alarm groups, held low until ready
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      alarm1_pin_o <= 1'b0;
      alarm2_pin_o <= 1'b0;
      status_pin_o <= 1'b0;
      alarm_trip_o <= 1'b0;
    end else begin
      alarm_trip_o <= |alarm_src_i;
      if (ctrl_r[`ARCI_CTRL_READY]) begin
        alarm1_pin_o <= al_sel[`ARCI_AL_OT] | al_sel[`ARCI_AL_PF];
        alarm2_pin_o <= al_sel[`ARCI_AL_OV] | al_sel[`ARCI_AL_OC] | al_sel[`ARCI_AL_OP];
        status_pin_o <= ctrl_r[`ARCI_CTRL_STMODE] ? dc_on_i : ~cv_active_i;
      end else begin
        alarm1_pin_o <= 1'b0;
        alarm2_pin_o <= 1'b0;
        status_pin_o <= 1'b0;
      end
    end
  end

  // only in remote control; leaving remote aborts
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_st_r  <= ARCI_ACK_IDLE;
      low_cnt_r <= `ARCI_ZERO32;
    end else if (!remote_act) begin
      ack_st_r  <= ARCI_ACK_IDLE;
      low_cnt_r <= `ARCI_ZERO32;
    end else begin
      unique case (ack_st_r)
        ARCI_ACK_IDLE: begin
          if (sby_lvl) begin
            ack_st_r <= ARCI_ACK_HIGH;
          end
        end
        ARCI_ACK_HIGH: begin
          // the first low cycle counts, so a low of exactly ACK_CYC cycles is accepted
          low_cnt_r <= sby_lvl ? `ARCI_ZERO32 : 32'h0000_0001;
          if (!sby_lvl) begin
            ack_st_r <= ARCI_ACK_LOW;
          end
        end
        ARCI_ACK_LOW: begin
          if (!sby_lvl) begin
            if (low_cnt_r < ACK_CYC) begin
              low_cnt_r <= low_cnt_r + 32'h0000_0001;
            end
          end else begin
            ack_st_r <= ARCI_ACK_HIGH;
          end
        end
        default: ack_st_r <= ARCI_ACK_IDLE;
      endcase
    end
  end

  assign ack_pulse = remote_act && (ack_st_r == ARCI_ACK_LOW) && sby_lvl
                     && (low_cnt_r >= ACK_CYC);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      alarm_ack_o <= 1'b0;
      ack_cnt_r   <= 8'h00;
    end else begin
      alarm_ack_o <= ack_pulse;
      if (ack_pulse) begin
        ack_cnt_r <= ack_cnt_r + 8'h01;
      end
    end
  end

  // avalon slave: one wait cycle per access
  assign acc     = (avs_read_i | avs_write_i) & ~rd_done_r;
  assign avs_waitrequest_o = acc;
  assign bank_lo = ~avs_address_i[4];
  assign ofs     = avs_address_i[3:0];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= acc;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r   <= `ARCI_CTRL_RST;
      almask_r <= `ARCI_ALMASK_RST;
    end else if (avs_write_i && rd_done_r && bank_lo && avs_byteenable_i[0]) begin
      if (ofs == `ARCI_OFS_CTRL) begin
        ctrl_r <= avs_writedata_i[`ARCI_CTRL_W-1:0];
      end
      if (ofs == `ARCI_OFS_ALMASK) begin
        almask_r <= avs_writedata_i[`ARCI_AL_W-1:0];
      end
    end
  end

  always_comb begin
    rd_nxt = `ARCI_ZERO32;
    if (bank_lo) begin
      unique case (ofs)
        `ARCI_OFS_CTRL:   rd_nxt[`ARCI_CTRL_W-1:0] = ctrl_r;
        `ARCI_OFS_ALMASK: rd_nxt[`ARCI_AL_W-1:0]   = almask_r;
        `ARCI_OFS_STATUS: begin
          rd_nxt[`ARCI_ST_REMOTE] = remote_act;
          rd_nxt[`ARCI_ST_RMODE]  = rmode_lvl;
          rd_nxt[`ARCI_ST_SBY]    = sby_lvl;
          rd_nxt[`ARCI_ST_DCON]   = dc_on_i;
          rd_nxt[`ARCI_ST_ALARM+`ARCI_AL_W-1:`ARCI_ST_ALARM] = alarm_src_i;
          rd_nxt[`ARCI_ST_ACKCNT+7:`ARCI_ST_ACKCNT] = ack_cnt_r;
        end
        `ARCI_OFS_SETV:   rd_nxt[`ARCI_CODE_W-1:0] = volt_set_o;
        default:          rd_nxt = `ARCI_ZERO32;
      endcase
    end else begin
      unique case (ofs)
        `ARCI_OFS_SETC: rd_nxt[`ARCI_CODE_W-1:0] = curr_set_o;
        `ARCI_OFS_SETR: rd_nxt[`ARCI_CODE_W-1:0] = res_set_o;
        `ARCI_OFS_MONV: rd_nxt[`ARCI_CODE_W-1:0] = voltage_monitor_out_o;
        `ARCI_OFS_MONC: rd_nxt[`ARCI_CODE_W-1:0] = current_monitor_out_o;
        default:        rd_nxt = `ARCI_ZERO32;
      endcase
    end
  end

  // read data registered in the wait cycle, stands at the release edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= `ARCI_ZERO32;
    end else if (avs_read_i && acc) begin
      avs_readdata_o <= rd_nxt;
    end
  end
endmodule

// ==== rtl/arci_defs.svh ====
/*
  constants for the analog remote control interface logic.
  assumes inclusion by the package, the top module and the bench.
*/
`ifndef ARCI_DEFS_SVH
`define ARCI_DEFS_SVH

// register byte offsets
`define ARCI_OFS_CTRL     4'h0
`define ARCI_OFS_ALMASK   4'h4
`define ARCI_OFS_STATUS   4'h8
`define ARCI_OFS_SETV     4'hC
// second bank (address bit 4 set)
`define ARCI_OFS_SETC     4'h0
`define ARCI_OFS_SETR     4'h4
`define ARCI_OFS_MONV     4'h8
`define ARCI_OFS_MONC     4'hC

// control register fields
`define ARCI_CTRL_RANGE10 0
`define ARCI_CTRL_STMODE  1
`define ARCI_CTRL_READY   2
`define ARCI_CTRL_W       3
`define ARCI_CTRL_RST     3'h0

// alarm source bits: overtemp, power fail, overvolt, overcurr, overpower
`define ARCI_AL_OT        0
`define ARCI_AL_PF        1
`define ARCI_AL_OV        2
`define ARCI_AL_OC        3
`define ARCI_AL_OP        4
`define ARCI_AL_W         5
`define ARCI_ALMASK_RST   5'h1F

// status register fields
`define ARCI_ST_REMOTE    0
`define ARCI_ST_RMODE     1
`define ARCI_ST_SBY       2
`define ARCI_ST_DCON      3
`define ARCI_ST_ALARM     4
`define ARCI_ST_ACKCNT    16

// acknowledgment low time
`define ARCI_ACK_LOW_MS   50
`define ARCI_CLK_HZ       20000000
`define ARCI_ACK_CYC      ((`ARCI_ACK_LOW_MS * `ARCI_CLK_HZ + 999) / 1000)

`define ARCI_ZERO32       32'h0000_0000
`define ARCI_CODE_W       14
`endif

// ==== rtl/arci_pkg.sv ====
/*
  types shared by the analog remote control interface logic.
  assumes arci_defs.svh is on the include path.
*/
`include "arci_defs.svh"
package arci_pkg;
  typedef logic [`ARCI_CODE_W-1:0] arci_code_t;
  typedef logic [`ARCI_AL_W-1:0]   arci_alarm_t;
  typedef enum logic [1:0] {
    ARCI_ACK_IDLE = 2'b00,
    ARCI_ACK_HIGH = 2'b01,
    ARCI_ACK_LOW  = 2'b10
  } arci_ack_t;
endpackage

// ==== sim/arci_checker.sv ====
/* checker for arci_top: alarm groups, acknowledgment, set values, monitors, pin decode.
   assumes only the top ports are visible; bound to arci_top at the foot. */
`timescale 1ns/100ps
module arci_checker #(
  parameter int unsigned ACK_CYC = 20
) (
  // clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  // pins and sources
  input wire logic                  remote_sel_pin_i,
  input wire logic                  rmode_pin_i,
  input wire logic                  standby_pin_i,
  input wire arci_pkg::arci_alarm_t alarm_src_i,
  input wire logic                  cv_active_i,
  input wire logic                  dc_on_i,
  input wire arci_pkg::arci_code_t  volt_actual_i,
  // outputs
  input wire arci_pkg::arci_code_t  volt_set_o,
  input wire logic                  set_valid_o,
  input wire logic                  rmode_on_o,
  input wire logic                  alarm_ack_o,
  input wire logic                  vref_10v_o,
  input wire arci_pkg::arci_code_t  voltage_monitor_out_o,
  input wire logic                  alarm1_pin_o,
  input wire logic                  alarm2_pin_o,
  input wire logic                  status_pin_o
);
  import arci_pkg::*;
  logic [31:0] low_cnt_r;
  logic [31:0] low_run_r;
  // raw low time equals the synchronised one, the sync delays both edges alike
  always_ff @(posedge core_clk_i) begin
    if (rst_i || standby_pin_i) begin
      low_cnt_r <= 32'h0000_0000;
    end else begin
      low_cnt_r <= low_cnt_r + 32'h0000_0001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      low_run_r <= 32'h0000_0000;
    end else if (standby_pin_i && low_cnt_r != 32'h0000_0000) begin
      low_run_r <= low_cnt_r;
    end
  end
  default clocking dcb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  al1_group_a: assert property (
    alarm1_pin_o |-> $past(alarm_src_i[0] || alarm_src_i[1])) else $error("alarm1 without cause");
  al2_group_a: assert property (
    alarm2_pin_o |-> $past(|alarm_src_i[4:2])) else $error("alarm2 without cause");
  ack_gate_a: assert property (
    alarm_ack_o |-> set_valid_o && low_run_r >= ACK_CYC ##1 !alarm_ack_o)
    else $error("ack pulse not justified");
  set_hold_a: assert property (
    !$past(rst_i) && !$stable(volt_set_o) |-> set_valid_o) else $error("set value moved in manual");
  mon_scale_a: assert property (
    !$past(rst_i) |-> voltage_monitor_out_o == ($past(volt_actual_i) & {13'h1FFF, $past(vref_10v_o)}))
    else $error("monitor code wrong");
  status_src_a: assert property (
    status_pin_o |-> $past(dc_on_i || !cv_active_i)) else $error("status high without cause");
  rmode_dec_a: assert property (
    $stable(rmode_pin_i) [*4] |-> rmode_on_o == rmode_pin_i) else $error("rmode decode wrong");
  remote_dec_a: assert property (
    $stable(remote_sel_pin_i) [*5] |-> set_valid_o != remote_sel_pin_i) else $error("remote decode wrong");
  cover property (alarm_ack_o);
  cover property (alarm1_pin_o);
  cover property (alarm2_pin_o);
endmodule
bind arci_top arci_checker #(.ACK_CYC(ACK_CYC)) arci_checker_inst (.*);

// ==== sim/arci_ctrl_model.sv ====
/* controller model on the remote pins: level requests and the acknowledgment pulse.
   assumes one calling process and a device sampling on core_clk_i. */
`timescale 1ns/100ps
module arci_ctrl_model (
  // clock
  input  wire logic core_clk_i,
  // pins toward the device
  output logic      remote_sel_pin_o,
  output logic      rmode_pin_o,
  output logic      standby_pin_o
);
  import arci_pkg::*;
  initial begin
    remote_sel_pin_o = 1'b1;
    rmode_pin_o = 1'b1;
    standby_pin_o = 1'b1;
  end
  task automatic pins(input logic r, input logic m, input logic s);
    @(posedge core_clk_i);
    remote_sel_pin_o <= r;
    rmode_pin_o <= m;
    standby_pin_o <= s;
  endtask
  task automatic ack(input int unsigned low_cyc);
    repeat (4) @(posedge core_clk_i);
    standby_pin_o <= 1'b0;
    repeat (low_cyc) @(posedge core_clk_i);
    standby_pin_o <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule

// ==== sim/tb_arci_top.sv ====
/* self-checking bench for arci_top with the controller model on its pins.
   assumes a 20 MHz clock and a shortened acknowledgment low time. */
`timescale 1ns/100ps
`include "arci_defs.svh"
`define ARCI_CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_arci_top;
  import arci_pkg::*;
  localparam int unsigned ACK = 20;
  int          num_errors = 0, check_count = 0, ack_seen = 0, cycles = 0;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic        cv_active_i = 1'b0, dc_on_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
  arci_alarm_t alarm_src_i = 5'h00;
  // set inputs held at defined levels
  arci_code_t  voltage_setpoint_in_i = 14'h1235, current_setpoint_in_i = 14'h0800;
  arci_code_t  resistance_setpoint_in_i = 14'h0400, volt_actual_i = 14'h0ACF;
  arci_code_t  curr_actual_i = 14'h0123, volt_set_o, curr_set_o, res_set_o;
  arci_code_t  voltage_monitor_out_o, current_monitor_out_o;
  logic        avs_waitrequest_o, remote_sel_pin_i, rmode_pin_i, standby_pin_i, set_valid_o;
  logic        rmode_on_o, dc_on_req_o, alarm_trip_o, alarm_ack_o, vref_10v_o;
  logic        alarm1_pin_o, alarm2_pin_o, status_pin_o;
  arci_top #(.ACK_CYC(ACK)) arci_top_inst (.*);
  arci_ctrl_model arci_ctrl_model_inst (
    .core_clk_i       (core_clk_i),
    .remote_sel_pin_o (remote_sel_pin_i),
    .rmode_pin_o      (rmode_pin_i),
    .standby_pin_o    (standby_pin_i)
  );
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic results;
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (alarm_ack_o === 1'b1) ack_seen <= ack_seen + 1;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    bus(1'b1, `ARCI_OFS_CTRL, 32'h0000_0005);
    bus(1'b0, `ARCI_OFS_CTRL, 32'h0000_0000);
    `ARCI_CHK("ctrl", 32'h0000_0005, q)
    bus(1'b0, 5'h02, 32'h0000_0000);
    `ARCI_CHK("unmapped", 32'h0000_0000, q)
    repeat (8) @(posedge core_clk_i);
    `ARCI_CHK("vset", 14'h0000, volt_set_o)
    `ARCI_CHK("valid", 1'b0, set_valid_o)
    `ARCI_CHK("voltage_monitor_out", 14'h0ACF, voltage_monitor_out_o)
    arci_ctrl_model_inst.pins(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge core_clk_i);
    `ARCI_CHK("vset", 14'h1235, volt_set_o)
    `ARCI_CHK("valid", 1'b1, set_valid_o)
    bus(1'b1, `ARCI_OFS_CTRL, 32'h0000_0004);
    repeat (8) @(posedge core_clk_i);
    `ARCI_CHK("vset5", 14'h1234, volt_set_o)
    `ARCI_CHK("vmon5", 14'h0ACE, voltage_monitor_out_o)
    `ARCI_CHK("vref", 1'b0, vref_10v_o)
    `ARCI_CHK("cset5", 14'h0800, curr_set_o)
    `ARCI_CHK("rset5", 14'h0400, res_set_o)
    `ARCI_CHK("cmon5", 14'h0122, current_monitor_out_o)
    bus(1'b0, 5'h1C, 32'h0000_0000);
    `ARCI_CHK("current_monitor_out_reg", 32'h0000_0122, q)
    for (int i = 0; i < 5; i++) begin
      alarm_src_i <= 5'h01 << i;
      repeat (4) @(posedge core_clk_i);
      `ARCI_CHK("al1", 1'(i < 2), alarm1_pin_o)
      `ARCI_CHK("al2", 1'(i > 1), alarm2_pin_o)
      `ARCI_CHK("trip", 1'b1, alarm_trip_o)
    end
    bus(1'b1, `ARCI_OFS_ALMASK, 32'h0000_001E);
    alarm_src_i <= 5'h01;
    repeat (4) @(posedge core_clk_i);
    `ARCI_CHK("mask", 1'b0, alarm1_pin_o)
    alarm_src_i <= 5'h00;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `ARCI_OFS_CTRL, 32'h0000_0004 | (i & 2));
      cv_active_i <= i[0];
      dc_on_i <= i[0];
      repeat (4) @(posedge core_clk_i);
      `ARCI_CHK("status", 1'(i[1] ~^ i[0]), status_pin_o)
      `ARCI_CHK("trip0", 1'b0, alarm_trip_o)
    end
    arci_ctrl_model_inst.pins(1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge core_clk_i);
    `ARCI_CHK("rmode", 1'b0, rmode_on_o)
    `ARCI_CHK("dcreq", 1'b0, dc_on_req_o)
    arci_ctrl_model_inst.pins(1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge core_clk_i);
    `ARCI_CHK("rmode", 1'b1, rmode_on_o)
    `ARCI_CHK("dcreq", 1'b1, dc_on_req_o)
    arci_ctrl_model_inst.ack(ACK - 1);
    `ARCI_CHK("ack_short", 0, ack_seen)
    arci_ctrl_model_inst.ack(ACK);
    `ARCI_CHK("ack", 1, ack_seen)
    arci_ctrl_model_inst.pins(1'b1, 1'b1, 1'b1);
    arci_ctrl_model_inst.ack(ACK + 2);
    `ARCI_CHK("ack_manual", 1, ack_seen)
    results();
  end
endmodule
